// file: core/pll_clock_select_control.sv
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module pll_clock_select_control
   import pll_clk_pkg::*;
(
   // Clock, reset and enable.
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   // Avalon-MM slave.
   input wire logic [3:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // Source and generated clocks.
   input wire logic OSC_CLK_I,
   input wire logic VCO_DIV_CLK_I,
   output logic BASE_CLK_O,
   output logic PLL_REF_CLK_O,
   // Analog loop.
   input wire logic LOCK_RAW_I,
   input wire logic TRACK_RAW_I,
   output pll_cfg_t PLL_CFG_O,
   output logic PLL_INT_O
);

   ////////////////////////////////////////////////////////////////////////
   // Register file and bus slave.

   logic wait_r, wait_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic ie_r, ie_nxt;
   logic flag_r, flag_nxt;
   logic on_r, on_nxt;
   logic bcs_r, bcs_nxt;
   logic [1:0] pre_r, pre_nxt;
   logic [1:0] vpr_r, vpr_nxt;
   logic auto_r, auto_nxt;
   logic acq_r, acq_nxt;
   logic [11:0] mul_r, mul_nxt;
   logic irq_r, irq_nxt;
   pll_cfg_t cfg_r, cfg_nxt;
   logic lock_s1_r, lock_s2_r, lock_s3_r;
   logic track_s1_r, track_s2_r;

   logic req, wr_go, rd_go, lock_chg, lock_bit, acq_bit;
   logic [7:0] ctrl_rd, bw_rd, wd;

   assign req = AVS_READ_I | AVS_WRITE_I;
   assign wd = AVS_WRITEDATA_I[7:0];
   // Only the low byte carries register bits.
   assign wr_go = AVS_WRITE_I & ~wait_r & AVS_BYTEENABLE_I[0];
   assign rd_go = AVS_READ_I & ~wait_r & (AVS_ADDRESS_I == ADDR_CTRL);
   assign lock_chg = lock_s2_r ^ lock_s3_r;
   assign lock_bit = auto_r & lock_s2_r;
   // In automatic mode the loop's own state is shown, not the stored bit.
   assign acq_bit = auto_r ? track_s2_r : acq_r;

   always_comb begin
      ctrl_rd = 8'h00;
      ctrl_rd[CTL_IE] = ie_r & auto_r;
      ctrl_rd[CTL_FLAG] = flag_r & auto_r;
      ctrl_rd[CTL_ON] = on_r;
      ctrl_rd[CTL_BCS] = bcs_r;
      ctrl_rd[CTL_PRE+:2] = pre_r;
      ctrl_rd[CTL_VPR+:2] = vpr_r;
      bw_rd = 8'h00;
      bw_rd[BW_AUTO] = auto_r;
      bw_rd[BW_LOCK] = lock_bit;
      bw_rd[BW_ACQ] = acq_bit;
   end

   always_comb begin
      wait_nxt = 1'b1;
      rdata_nxt = rdata_r;
      ie_nxt = ie_r;
      on_nxt = on_r;
      bcs_nxt = bcs_r;
      pre_nxt = pre_r;
      vpr_nxt = vpr_r;
      auto_nxt = auto_r;
      acq_nxt = acq_r;
      mul_nxt = mul_r;
      // The answer is registered on the same edge that waitrequest falls.
      if (req && wait_r) begin
         wait_nxt = 1'b0;
         case (AVS_ADDRESS_I)
            ADDR_CTRL: rdata_nxt = {24'h00_0000, ctrl_rd};
            ADDR_BW: rdata_nxt = {24'h00_0000, bw_rd};
            ADDR_MULH: rdata_nxt = {28'h000_0000, mul_r[11:8]};
            ADDR_MULL: rdata_nxt = {24'h00_0000, mul_r[7:0]};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
      if (wr_go) begin
         case (AVS_ADDRESS_I)
            ADDR_CTRL: begin
               if (auto_r) begin
                  ie_nxt = wd[CTL_IE];
               end
               // Turning off is refused while the base select bit picks the VCO.
               if (wd[CTL_ON] || !bcs_r) begin
                  on_nxt = wd[CTL_ON];
               end
               // Both checks use the old bits, so one write can turn the PLL off
               // and select the VCO together.
               if (!wd[CTL_BCS] || on_r) begin
                  bcs_nxt = wd[CTL_BCS];
               end
               if (!on_r) begin
                  pre_nxt = wd[CTL_PRE+:2];
                  vpr_nxt = wd[CTL_VPR+:2];
               end
            end
            ADDR_BW: begin
               auto_nxt = wd[BW_AUTO];
               // Writes in automatic mode leave the manual value alone.
               if (!auto_r) begin
                  acq_nxt = wd[BW_ACQ];
               end
            end
            ADDR_MULH: begin
               if (!on_r) begin
                  mul_nxt = {wd[3:0], mul_r[7:0]};
               end
            end
            ADDR_MULL: begin
               if (!on_r) begin
                  mul_nxt = {mul_r[11:8], wd};
               end
            end
            default: begin
               mul_nxt = mul_r;
            end
         endcase
      end
   end

   // A lock change in the clearing cycle wins over the read.
   always_comb begin
      // Clearing automatic mode drops the flag on the same edge, so a
      // stale flag can never be seen in manual mode.
      if (!auto_nxt) begin
         flag_nxt = 1'b0;
      end else if (lock_chg) begin
         flag_nxt = 1'b1;
      end else if (rd_go) begin
         flag_nxt = 1'b0;
      end else begin
         flag_nxt = flag_r;
      end
      irq_nxt = flag_r & ie_r & auto_r;
      cfg_nxt.on = on_nxt;
      cfg_nxt.pre = pre_nxt;
      cfg_nxt.vpr = vpr_nxt;
      cfg_nxt.mul = (mul_nxt == 12'h000) ? MUL_ONE : mul_nxt;
      cfg_nxt.auto_bw = auto_nxt;
      cfg_nxt.acquisition_mode_bit = acq_nxt;
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         wait_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
         ie_r <= 1'b0;
         flag_r <= 1'b0;
         on_r <= ON_RST;
         bcs_r <= 1'b0;
         pre_r <= 2'h0;
         vpr_r <= 2'h0;
         auto_r <= 1'b0;
         acq_r <= 1'b0;
         mul_r <= MUL_RST;
         irq_r <= 1'b0;
         cfg_r <= '{ON_RST, 2'h0, 2'h0, MUL_RST, 1'b0, 1'b0};
         lock_s1_r <= 1'b0;
         lock_s2_r <= 1'b0;
         lock_s3_r <= 1'b0;
         track_s1_r <= 1'b0;
         track_s2_r <= 1'b0;
      end else if (CE_I) begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
         ie_r <= ie_nxt;
         flag_r <= flag_nxt;
         on_r <= on_nxt;
         bcs_r <= bcs_nxt;
         pre_r <= pre_nxt;
         vpr_r <= vpr_nxt;
         auto_r <= auto_nxt;
         acq_r <= acq_nxt;
         mul_r <= mul_nxt;
         irq_r <= irq_nxt;
         cfg_r <= cfg_nxt;
         // The analog lock and mode levels are asynchronous.
         lock_s1_r <= LOCK_RAW_I;
         lock_s2_r <= lock_s1_r;
         lock_s3_r <= lock_s2_r;
         track_s1_r <= TRACK_RAW_I;
         track_s2_r <= track_s1_r;
      end
   end

   assign AVS_WAITREQUEST_O = wait_r;
   assign AVS_READDATA_O = rdata_r;
   assign PLL_INT_O = irq_r;
   assign PLL_CFG_O = cfg_r;

   ////////////////////////////////////////////////////////////////////////
   // Base clock selector.
   // Both sources are sampled by the bus clock, so each must run below
   // half of it; this keeps the whole block in one clock domain.

   sw_state_t sw_r, sw_nxt;
   logic sel_r, sel_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic base_r, base_nxt;
   logic ref_r;
   logic osc_q_r, vco_q_r;
   logic osc_rise, vco_rise, cur_rise, alt_rise;

   assign osc_rise = OSC_CLK_I & ~osc_q_r;
   assign vco_rise = VCO_DIV_CLK_I & ~vco_q_r;
   assign cur_rise = sel_r ? vco_rise : osc_rise;
   assign alt_rise = sel_r ? osc_rise : vco_rise;

   always_comb begin
      sw_nxt = sw_r;
      sel_nxt = sel_r;
      cnt_nxt = cnt_r;
      base_nxt = base_r;
      case (sw_r)
         SW_RUN: begin
            if (bcs_r != sel_r) begin
               sw_nxt = SW_OLD;
               cnt_nxt = 2'h0;
            end else if (cur_rise) begin
               // One toggle per source rise halves it at even duty.
               base_nxt = ~base_r;
            end
         end
         SW_OLD: begin
            if (cur_rise) begin
               cnt_nxt = 2'(cnt_r + 2'h1);
               if (cnt_r == SW_EDGES - 2'h1) begin
                  sw_nxt = SW_NEW;
                  sel_nxt = ~sel_r;
                  cnt_nxt = 2'h0;
               end
            end
         end
         SW_NEW: begin
            if (cur_rise) begin
               cnt_nxt = 2'(cnt_r + 2'h1);
               if (cnt_r == SW_EDGES - 2'h1) begin
                  sw_nxt = SW_RUN;
                  cnt_nxt = 2'h0;
               end
            end
         end
         default: begin
            sw_nxt = SW_RUN;
            cnt_nxt = 2'h0;
         end
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         sw_r <= SW_RUN;
         sel_r <= 1'b0;
         cnt_r <= 2'h0;
         base_r <= 1'b0;
         ref_r <= 1'b0;
         osc_q_r <= 1'b0;
         vco_q_r <= 1'b0;
      end else if (CE_I) begin
         sw_r <= sw_nxt;
         sel_r <= sel_nxt;
         cnt_r <= cnt_nxt;
         base_r <= base_nxt;
         ref_r <= OSC_CLK_I;
         osc_q_r <= OSC_CLK_I;
         vco_q_r <= VCO_DIV_CLK_I;
      end
   end

   assign BASE_CLK_O = base_r;
   assign PLL_REF_CLK_O = ref_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (RST_I);

   ie_read_zero_a: assert property (
      CE_I && req && wait_r && AVS_ADDRESS_I == ADDR_CTRL && !auto_r
      |=> !AVS_READDATA_O[CTL_IE] && !AVS_READDATA_O[CTL_FLAG])
      else $error("enable or flag read nonzero in manual mode");

   flag_on_lock_a: assert property (
      CE_I && auto_nxt && lock_chg |=> flag_r)
      else $error("lock change did not set flag");

   irq_follows_a: assert property (
      CE_I && flag_r && ie_r && auto_r |=> PLL_INT_O)
      else $error("interrupt missing with flag and enable set");

   flag_read_clr_a: assert property (
      CE_I && rd_go && !lock_chg |=> !flag_r)
      else $error("control read did not clear flag");

   on_kept_a: assert property (
      CE_I && wr_go && AVS_ADDRESS_I == ADDR_CTRL && bcs_r
      && !wd[CTL_ON] |=> on_r)
      else $error("PLL turned off while VCO selected");

   bcs_guard_a: assert property (
      CE_I && wr_go && AVS_ADDRESS_I == ADDR_CTRL && !on_r
      |=> bcs_r == $past(bcs_r))
      else $error("base select set while PLL off");

   pre_locked_a: assert property (
      CE_I && on_r |=> pre_r == $past(pre_r) && vpr_r == $past(vpr_r))
      else $error("prescaler or range changed while PLL on");

   mul_nonzero_a: assert property (
      PLL_CFG_O.mul != 12'h000)
      else $error("multiplier output is zero");

   base_static_a: assert property (
      sw_r != SW_RUN |=> $stable(BASE_CLK_O))
      else $error("base clock moved during switch");

   base_toggle_a: assert property (
      !RST_I && CE_I && sw_r == SW_RUN && bcs_r == sel_r && cur_rise
      |=> BASE_CLK_O != $past(BASE_CLK_O))
      else $error("base clock missed a source rise");

   ref_copy_a: assert property (
      !RST_I && CE_I |=> PLL_REF_CLK_O == $past(OSC_CLK_I))
      else $error("reference clock is not a copy of the oscillator");

   lock_view_a: assert property (
      !auto_r |-> !lock_bit && !flag_r)
      else $error("lock or flag visible in manual mode");

   acq_restore_a: assert property (
      CE_I && auto_r |=> acq_r == $past(acq_r))
      else $error("manual acquisition value lost in automatic mode");

endmodule

// file: core/pll_clk_pkg.sv
package pll_clk_pkg;

   // Register byte addresses on the 32-bit bus.
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_BW = 4'h4;
   localparam logic [3:0] ADDR_MULH = 4'h8;
   localparam logic [3:0] ADDR_MULL = 4'hC;

   // Control register fields.
   localparam int CTL_IE = 7;
   localparam int CTL_FLAG = 6;
   localparam int CTL_ON = 5;
   localparam int CTL_BCS = 4;
   localparam int CTL_PRE = 2;
   localparam int CTL_VPR = 0;

   // Bandwidth register fields.
   localparam int BW_AUTO = 7;
   localparam int BW_LOCK = 6;
   localparam int BW_ACQ = 5;

   // Reset values, and the multiplier put out in place of zero.
   localparam logic ON_RST = 1'b1;
   localparam logic [11:0] MUL_RST = 12'h040;
   localparam logic [11:0] MUL_ONE = 12'h001;

   // Source edges waited on each side of a clock switch.
   localparam logic [1:0] SW_EDGES = 2'h3;

   typedef struct packed {
      logic on;
      logic [1:0] pre;
      logic [1:0] vpr;
      logic [11:0] mul;
      logic auto_bw;
      logic acquisition_mode_bit;
   } pll_cfg_t;

   typedef enum logic [1:0] {
      SW_RUN = 2'b00,
      SW_OLD = 2'b01,
      SW_NEW = 2'b10
   } sw_state_t;

endpackage

// file: sim/pll_loop_model.sv
`timescale 1ns/1ps
// Stand-in for the analog loop: two free-running source clocks, slower
// than half the system clock, and raw lock and tracking levels that follow
// the bench's requests one cycle late.
module pll_loop_model #(
   parameter int OSC_H = 4,
   parameter int VCO_H = 3
) (
   // Clock and requests.
   input wire logic clk_i,
   input wire logic lock_req_i,
   input wire logic track_req_i,
   // Loop outputs.
   output logic osc_o,
   output logic vco_o,
   output logic lock_o,
   output logic track_o
);
   int oc = 0;
   int vc = 0;
   initial begin
      osc_o = 1'b0;
      vco_o = 1'b0;
      lock_o = 1'b0;
      track_o = 1'b0;
   end
   always @(posedge clk_i) begin
      oc <= (oc == OSC_H - 1) ? 0 : oc + 1;
      vc <= (vc == VCO_H - 1) ? 0 : vc + 1;
      if (oc == OSC_H - 1) begin
         osc_o <= ~osc_o;
      end
      if (vc == VCO_H - 1) begin
         vco_o <= ~vco_o;
      end
      lock_o <= lock_req_i;
      track_o <= track_req_i;
   end
endmodule

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
   import pll_clk_pkg::*;
   logic MCLK_I, RST_I, AVS_READ_I, AVS_WRITE_I;
   logic [3:0] AVS_ADDRESS_I, AVS_BYTEENABLE_I;
   logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O;
   logic AVS_WAITREQUEST_O, OSC_CLK_I, VCO_DIV_CLK_I, BASE_CLK_O;
   logic PLL_REF_CLK_O, LOCK_RAW_I, TRACK_RAW_I, PLL_INT_O;
   pll_cfg_t PLL_CFG_O;
   logic lock_req, track_req;
   logic [31:0] rdata, n;
   int miscompares = 0;
   int checks_done = 0;

   pll_clock_select_control uut (.MCLK_I(MCLK_I), .RST_I(RST_I),
      .CE_I(1'b1), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
      .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
      .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
      .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .OSC_CLK_I(OSC_CLK_I),
      .VCO_DIV_CLK_I(VCO_DIV_CLK_I), .BASE_CLK_O(BASE_CLK_O),
      .PLL_REF_CLK_O(PLL_REF_CLK_O), .LOCK_RAW_I(LOCK_RAW_I),
      .TRACK_RAW_I(TRACK_RAW_I), .PLL_CFG_O(PLL_CFG_O),
      .PLL_INT_O(PLL_INT_O));
   pll_loop_model loop (.clk_i(MCLK_I), .lock_req_i(lock_req),
      .track_req_i(track_req), .osc_o(OSC_CLK_I), .vco_o(VCO_DIV_CLK_I),
      .lock_o(LOCK_RAW_I), .track_o(TRACK_RAW_I));

   initial begin
      MCLK_I = 1'b0;
      forever #25 MCLK_I = ~MCLK_I;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // The request is held until waitrequest is sampled low at a rising edge.
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] be);
      int i;
      @(posedge MCLK_I);
      AVS_ADDRESS_I <= a;
      AVS_WRITEDATA_I <= d;
      AVS_BYTEENABLE_I <= be;
      AVS_WRITE_I <= w;
      AVS_READ_I <= ~w;
      i = 0;
      do begin
         @(posedge MCLK_I);
         i++;
      end while (AVS_WAITREQUEST_O !== 1'b0 && i < 50);
      rdata = AVS_READDATA_O;
      if (i >= 50) begin
         miscompares++;
      end
      AVS_WRITE_I <= 1'b0;
      AVS_READ_I <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 4'h1);
      chk(rdata, exp);
   endtask

   // Cycles between two changes of the base clock after the next change.
   task automatic half_period(output logic [31:0] cnt);
      logic b;
      int i;
      b = BASE_CLK_O;
      i = 0;
      while (BASE_CLK_O === b && i < 200) begin
         @(posedge MCLK_I);
         i++;
      end
      b = BASE_CLK_O;
      cnt = 0;
      while (BASE_CLK_O === b && cnt < 200) begin
         @(posedge MCLK_I);
         cnt++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic p;
      rd(ADDR_CTRL, 32'h0000_0020);
      rd(ADDR_BW, 32'h0000_0000);
      rd(ADDR_MULL, 32'h0000_0040);
      rd(4'h2, 32'h0000_0000);
      chk(32'(PLL_CFG_O.mul), 32'h0000_0040);
      half_period(n);
      chk(n, 32'h0000_0008);
      @(negedge MCLK_I);
      repeat (20) begin
         p = OSC_CLK_I;
         @(negedge MCLK_I);
         chk(32'(PLL_REF_CLK_O), 32'(p));
      end
      $display("done: reset state");
   endtask

   task automatic t_protect;
      wr(ADDR_CTRL, 32'h0000_002E);
      rd(ADDR_CTRL, 32'h0000_0020);
      wr(ADDR_MULL, 32'h0000_0000);
      rd(ADDR_MULL, 32'h0000_0040);
      bus(1'b1, ADDR_CTRL, 32'h0000_000E, 4'h0);
      rd(ADDR_CTRL, 32'h0000_0020);
      wr(ADDR_CTRL, 32'h0000_000E);
      rd(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_000E);
      rd(ADDR_CTRL, 32'h0000_000E);
      wr(ADDR_MULH, 32'h0000_0000);
      wr(ADDR_MULL, 32'h0000_0000);
      @(negedge MCLK_I);
      chk(32'(PLL_CFG_O.mul), 32'h0000_0001);
      wr(ADDR_MULH, 32'h0000_0001);
      wr(ADDR_MULL, 32'h0000_0023);
      rd(ADDR_MULH, 32'h0000_0001);
      chk(32'(PLL_CFG_O.mul), 32'h0000_0123);
      wr(ADDR_CTRL, 32'h0000_008E);
      rd(ADDR_CTRL, 32'h0000_000E);
      lock_req <= 1'b1;
      repeat (8) @(posedge MCLK_I);
      chk(32'(PLL_INT_O), 32'h0000_0000);
      rd(ADDR_CTRL, 32'h0000_000E);
      lock_req <= 1'b0;
      repeat (8) @(posedge MCLK_I);
      $display("done: write protection");
   endtask

   task automatic t_select;
      logic b;
      wr(ADDR_CTRL, 32'h0000_001E);
      rd(ADDR_CTRL, 32'h0000_000E);
      wr(ADDR_BW, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_002E);
      rd(ADDR_CTRL, 32'h0000_002E);
      wr(ADDR_CTRL, 32'h0000_003E);
      repeat (2) @(posedge MCLK_I);
      b = BASE_CLK_O;
      repeat (18) begin
         @(posedge MCLK_I);
         chk(32'(BASE_CLK_O), 32'(b));
      end
      rd(ADDR_CTRL, 32'h0000_003E);
      repeat (60) @(posedge MCLK_I);
      half_period(n);
      chk(n, 32'h0000_0006);
      wr(ADDR_CTRL, 32'h0000_000E);
      rd(ADDR_CTRL, 32'h0000_002E);
      $display("done: clock select");
   endtask

   task automatic t_lock;
      wr(ADDR_BW, 32'h0000_0080);
      wr(ADDR_CTRL, 32'h0000_00BE);
      rd(ADDR_CTRL, 32'h0000_00BE);
      lock_req <= 1'b1;
      track_req <= 1'b1;
      repeat (8) @(posedge MCLK_I);
      chk(32'(PLL_INT_O), 32'h0000_0001);
      rd(ADDR_BW, 32'h0000_00E0);
      rd(ADDR_CTRL, 32'h0000_00FE);
      rd(ADDR_CTRL, 32'h0000_00BE);
      repeat (2) @(posedge MCLK_I);
      chk(32'(PLL_INT_O), 32'h0000_0000);
      $display("done: lock event");
   endtask

   task automatic t_acq;
      wr(ADDR_BW, 32'h0000_0000);
      rd(ADDR_BW, 32'h0000_0000);
      rd(ADDR_CTRL, 32'h0000_003E);
      wr(ADDR_BW, 32'h0000_0020);
      rd(ADDR_BW, 32'h0000_0020);
      track_req <= 1'b0;
      wr(ADDR_BW, 32'h0000_00A0);
      repeat (4) @(posedge MCLK_I);
      rd(ADDR_BW, 32'h0000_00C0);
      // A write in automatic mode must not touch the stored manual value.
      wr(ADDR_BW, 32'h0000_0080);
      wr(ADDR_BW, 32'h0000_0000);
      rd(ADDR_BW, 32'h0000_0020);
      @(negedge MCLK_I);
      chk(32'(PLL_CFG_O.acquisition_mode_bit), 32'h0000_0001);
      $display("done: acquisition bit");
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      RST_I = 1'b1;
      AVS_READ_I = 1'b0;
      AVS_WRITE_I = 1'b0;
      AVS_ADDRESS_I = 4'h0;
      AVS_WRITEDATA_I = 32'h0000_0000;
      AVS_BYTEENABLE_I = 4'h0;
      lock_req = 1'b0;
      track_req = 1'b0;
      repeat (10) @(posedge MCLK_I);
      RST_I <= 1'b0;
      t_reset;
      t_protect;
      t_select;
      t_lock;
      t_acq;
      summarize;
   end

   // The tests need well under a thousand cycles; this bound is generous.
   initial begin
      #1000000;
      miscompares++;
      $display("watchdog expired");
      summarize;
   end
endmodule
